//--- iod_io_decoder.sv
`timescale 1ns/1ps
module iod_io_decoder #(
	parameter int NUM_TRAP = iod_pkg::NUM_TRAP_MAX,
	parameter int NUM_PCIE = iod_pkg::NUM_PCIE_MAX
) (
	// Clock and reset
	input  wire logic                              core_clk,
	input  wire logic                              rst_n,
	// Wishbone slave
	input  wire logic                              wb_cyc,
	input  wire logic                              wb_stb,
	input  wire logic                              wb_we,
	input  wire logic [iod_pkg::WB_ADDR_W-1:0]     wb_adr,
	input  wire logic                        [3:0] wb_sel,
	input  wire logic                       [31:0] wb_wdata,
	output logic                            [31:0] wb_rdata,
	output logic                                   wb_ack,
	// I/O cycle from upstream link
	input  wire logic                              io_valid,
	input  wire logic                              io_write,
	input  wire logic                       [15:0] io_addr,
	input  wire logic                        [7:0] io_wdata,
	// Routed cycle
	output logic                                   rt_valid,
	output iod_pkg::iod_target_e                   rt_target,
	output logic                             [4:0] rt_port,
	output logic                            [15:0] rt_addr,
	output logic                                   rt_write,
	output logic                             [7:0] rt_wdata,
	// Internal completion
	output logic                                   cpl_valid,
	output logic                             [7:0] cpl_rdata
);
	import iod_pkg::*;

	if (NUM_TRAP < 1 || NUM_TRAP > NUM_TRAP_MAX) begin : g_chk_trap
		$error("NUM_TRAP out of range");
	end
	if (NUM_PCIE < 1 || NUM_PCIE > NUM_PCIE_MAX) begin : g_chk_pcie
		$error("NUM_PCIE out of range");
	end

	typedef struct packed {
		logic                         ack;
		logic                  [31:0] rdata;
		logic [NUM_REGS-1:0]   [31:0] regs;
		logic                         rt_valid;
		iod_target_e                  rt_target;
		logic                   [4:0] rt_port;
		logic                  [15:0] rt_addr;
		logic                         rt_write;
		logic                   [7:0] rt_wdata;
		logic                         cpl_valid;
		logic                   [7:0] cpl_rdata;
		logic                  [15:0] route_count;
		logic                  [15:0] term_count;
	} iod_state_s;

	iod_state_s s_reg;
	iod_state_s s_next;

	// Window table
	logic        [NUM_WIN-1:0][15:0] win_base;
	logic        [NUM_WIN-1:0][16:0] win_limit;
	logic        [NUM_WIN-1:0][4:0]  win_port;
	logic        [NUM_WIN-1:0]       win_en;
	logic        [NUM_WIN-1:0]       win_hit;
	iod_target_e                     win_tgt [NUM_WIN];
	logic                            var_hit;
	logic                      [4:0] var_idx;

	// Fixed decode
	logic                            fix_hit;
	iod_target_e                     fix_tgt;
	logic                     [15:0] fix_addr;

	// Bus helpers
	logic                      [5:0] reg_idx;
	logic                     [31:0] byte_en;
	logic                            bus_req;
	logic                            bus_wr;

	function automatic logic [31:0] reg_mask(input int i);
		if (i == REG_CTRL) return MASK_CTRL;
		if (i == REG_LEGACY) return MASK_LEGACY;
		if (i == REG_IDE) return MASK_IDE;
		if (i >= REG_LPC0 && i < REG_TRAP0) return MASK_GEN;
		if (i >= REG_TRAP0 && i < REG_TRAP0 + NUM_TRAP) return MASK_GEN;
		if (i >= REG_TRAP0 && i < REG_PCIE0) return '0;
		if (i >= REG_PCIE0 && i < REG_PCIE0 + NUM_PCIE) return MASK_PCIE;
		if (i >= REG_PCIE0) return '0;
		return MASK_EN_BASE;
	endfunction

	function automatic logic [16:0] win_last(input logic [15:0] base, input logic [15:0] mask);
		return {1'b0, base | mask};
	endfunction

	iod_fixed_decode u_fixed (
		.addr                        (io_addr),
		.write                       (io_write),
		.post_code_route_select      (s_reg.regs[REG_CTRL][CTRL_POST_ROUTE]),
		.nmi_port_alias_enable       (s_reg.regs[REG_CTRL][CTRL_NMI_ALIAS]),
		.low_gameport_decode_enable  (s_reg.regs[REG_CTRL][CTRL_LOW_GAME]),
		.high_gameport_decode_enable (s_reg.regs[REG_CTRL][CTRL_HIGH_GAME]),
		.hit                         (fix_hit),
		.target                      (fix_tgt),
		.fwd_addr                    (fix_addr)
	);

	// Window placement from programmed registers
	always_comb begin
		logic [31:0] w;
		logic [15:0] m;
		logic  [1:0] psel;
		w = '0;
		m = '0;
		psel = '0;
		for (int i = 0; i < NUM_WIN; i++) begin
			win_base[i] = '0;
			win_limit[i] = '0;
			win_en[i] = 1'b0;
			win_tgt[i] = TGT_UNCLAIMED;
			win_port[i] = '0;
		end

		w = s_reg.regs[REG_ACPI];
		win_en[WIN_ACPI] = w[EN_BIT];
		win_base[WIN_ACPI] = w[15:0];
		win_limit[WIN_ACPI] = {1'b0, w[15:0]} + ACPI_LAST;
		win_tgt[WIN_ACPI] = TGT_POWER_MGMT;

		w = s_reg.regs[REG_IDE];
		m = w[IDE_SIZE32_BIT] ? IDE_MASK32 : IDE_MASK16;
		win_en[WIN_IDE] = w[EN_BIT];
		win_base[WIN_IDE] = w[15:0] & ~m;
		win_limit[WIN_IDE] = win_last(w[15:0], m);
		win_tgt[WIN_IDE] = TGT_DISK_REDIRECT;

		w = s_reg.regs[REG_SMB];
		win_en[WIN_SMB] = w[EN_BIT];
		win_base[WIN_SMB] = w[15:0] & ~SMB_MASK;
		win_limit[WIN_SMB] = win_last(w[15:0], SMB_MASK);
		win_tgt[WIN_SMB] = TGT_SMBUS;

		w = s_reg.regs[REG_WDT];
		win_en[WIN_WDT] = w[EN_BIT];
		win_base[WIN_WDT] = w[15:0] & ~SMB_MASK;
		win_limit[WIN_WDT] = win_last(w[15:0], SMB_MASK);
		win_tgt[WIN_WDT] = TGT_SMBUS;

		// Legacy peripherals pick a fixed 8-byte location, not always aligned
		w = s_reg.regs[REG_LEGACY];
		psel = w[PAR_SEL_LSB +: 2];
		win_en[WIN_PAR] = w[PAR_EN] && (psel != PAR_SEL_NONE);
		win_base[WIN_PAR] = (psel == PAR_SEL_NONE) ? '0 : PAR_LOC[psel];
		win_en[WIN_SER1] = w[SER1_EN];
		win_base[WIN_SER1] = SER_LOC[w[SER1_SEL_LSB +: 3]];
		win_en[WIN_SER2] = w[SER2_EN];
		win_base[WIN_SER2] = SER_LOC[w[SER2_SEL_LSB +: 3]];
		win_en[WIN_FDC] = w[FDC_EN];
		win_base[WIN_FDC] = FDC_LOC[w[FDC_SEL]];
		for (int i = WIN_PAR; i <= WIN_FDC; i++) begin
			win_limit[i] = {1'b0, win_base[i]} + {1'b0, LEGACY_MASK};
			win_tgt[i] = TGT_LPC;
		end

		w = s_reg.regs[REG_SATA];
		win_en[WIN_SATA] = w[EN_BIT];
		win_base[WIN_SATA] = w[15:0] & ~SATA_MASK;
		win_limit[WIN_SATA] = win_last(w[15:0], SATA_MASK);
		win_tgt[WIN_SATA] = TGT_SATA;

		w = s_reg.regs[REG_KT];
		win_en[WIN_KT] = w[EN_BIT];
		win_base[WIN_KT] = w[15:0] & ~KT_MASK;
		win_limit[WIN_KT] = win_last(w[15:0], KT_MASK);
		win_tgt[WIN_KT] = TGT_KEYBOARD_TEXT;

		// Size mask need not be contiguous; window spans base..base|mask
		for (int i = 0; i < 4; i++) begin
			w = s_reg.regs[REG_LPC0 + i];
			m = {8'h00, w[GEN_MASK_LSB +: 8] | LPC_MIN_MASK};
			win_en[WIN_LPC0 + i] = w[EN_BIT];
			win_base[WIN_LPC0 + i] = w[15:0] & ~m;
			win_limit[WIN_LPC0 + i] = win_last(w[15:0], m);
			win_tgt[WIN_LPC0 + i] = TGT_LPC;
			win_port[WIN_LPC0 + i] = 5'(i);
		end

		for (int i = 0; i < NUM_TRAP; i++) begin
			w = s_reg.regs[REG_TRAP0 + i];
			m = {8'h00, w[GEN_MASK_LSB +: 8]};
			win_en[WIN_TRAP0 + i] = w[EN_BIT];
			win_base[WIN_TRAP0 + i] = w[15:0] & ~m;
			win_limit[WIN_TRAP0 + i] = win_last(w[15:0], m);
			win_tgt[WIN_TRAP0 + i] = TGT_TRAP;
			win_port[WIN_TRAP0 + i] = 5'(i);
		end

		// Empty bridge window when limit below base
		for (int i = 0; i < NUM_PCIE; i++) begin
			w = s_reg.regs[REG_PCIE0 + i];
			win_en[WIN_PCIE0 + i] = w[PCIE_LIMIT_LSB +: 16] >= w[15:0];
			win_base[WIN_PCIE0 + i] = w[15:0];
			win_limit[WIN_PCIE0 + i] = {1'b0, w[PCIE_LIMIT_LSB +: 16]};
			win_tgt[WIN_PCIE0 + i] = TGT_PCIE;
			win_port[WIN_PCIE0 + i] = 5'(i);
		end
	end

	for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
		iod_window_match u_match (
			.addr_en (win_en[g]),
			.addr    (io_addr),
			.base    (win_base[g]),
			.limit   (win_limit[g]),
			.hit     (win_hit[g])
		);
	end

	// Overlaps are not flagged; lowest window index simply wins
	always_comb begin
		var_hit = 1'b0;
		var_idx = '0;
		for (int i = NUM_WIN - 1; i >= 0; i--) begin
			if (win_hit[i]) begin
				var_hit = 1'b1;
				var_idx = 5'(i);
			end
		end
	end

	assign reg_idx = wb_adr[WB_ADDR_W-1:2];
	assign bus_req = wb_cyc && wb_stb && !s_reg.ack;
	assign bus_wr = bus_req && wb_we;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			byte_en[b*8 +: 8] = {8{wb_sel[b]}};
		end
	end

	always_comb begin
		iod_target_e tgt;
		logic [15:0] fwd;
		logic  [4:0] port;
		tgt = TGT_UNCLAIMED;
		fwd = io_addr;
		port = '0;
		s_next = s_reg;

		// Register bus, ack one cycle after the request is seen
		s_next.ack = bus_req;
		if (bus_req) begin
			if (reg_idx < 6'(NUM_REGS)) begin
				s_next.rdata = s_reg.regs[reg_idx];
			end else if (reg_idx == 6'(REG_STATUS)) begin
				s_next.rdata = '0;
				s_next.rdata[3:0] = s_reg.rt_target;
				s_next.rdata[STAT_PORT_LSB +: 5] = s_reg.rt_port;
				s_next.rdata[STAT_WRITE] = s_reg.rt_write;
			end else if (reg_idx == 6'(REG_ROUTE_COUNT)) begin
				s_next.rdata = {16'h0000, s_reg.route_count};
			end else if (reg_idx == 6'(REG_TERM_COUNT)) begin
				s_next.rdata = {16'h0000, s_reg.term_count};
			end else begin
				s_next.rdata = '0;
			end
		end
		for (int i = 0; i < NUM_REGS; i++) begin
			if (bus_wr && reg_idx == 6'(i)) begin
				s_next.regs[i] = ((s_reg.regs[i] & ~byte_en) | (wb_wdata & byte_en))
					& reg_mask(i);
			end
		end

		// One decision per cycle, fixed map ahead of variable windows
		if (fix_hit) begin
			tgt = fix_tgt;
			fwd = fix_addr;
		end else if (var_hit) begin
			tgt = win_tgt[var_idx];
			port = win_port[var_idx];
		end
		s_next.rt_valid = 1'b0;
		s_next.cpl_valid = 1'b0;
		if (io_valid) begin
			s_next.rt_target = tgt;
			s_next.rt_port = port;
			s_next.rt_addr = fwd;
			s_next.rt_write = io_write;
			s_next.rt_wdata = io_wdata;
			if (tgt == TGT_RESERVED || tgt == TGT_UNCLAIMED) begin
				s_next.cpl_valid = 1'b1;
				s_next.cpl_rdata = io_write ? 8'h00 : RESERVED_RDATA;
				s_next.term_count = s_reg.term_count + 16'h0001;
			end else begin
				s_next.rt_valid = 1'b1;
				s_next.route_count = s_reg.route_count + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack = s_reg.ack;
	assign wb_rdata = s_reg.rdata;
	assign rt_valid = s_reg.rt_valid;
	assign rt_target = s_reg.rt_target;
	assign rt_port = s_reg.rt_port;
	assign rt_addr = s_reg.rt_addr;
	assign rt_write = s_reg.rt_write;
	assign rt_wdata = s_reg.rt_wdata;
	assign cpl_valid = s_reg.cpl_valid;
	assign cpl_rdata = s_reg.cpl_rdata;
endmodule

//--- iod_pkg.sv
package iod_pkg;

	// Register bus
	localparam int WB_ADDR_W = 8;
	localparam int NUM_TRAP_MAX = 4;
	localparam int NUM_PCIE_MAX = 12;

	// Register indices, byte address is four times the index
	localparam int REG_CTRL = 0;
	localparam int REG_LEGACY = 1;
	localparam int REG_ACPI = 2;
	localparam int REG_IDE = 3;
	localparam int REG_SMB = 4;
	localparam int REG_WDT = 5;
	localparam int REG_SATA = 6;
	localparam int REG_KT = 7;
	localparam int REG_LPC0 = 8;
	localparam int REG_TRAP0 = 12;
	localparam int REG_PCIE0 = 16;
	localparam int NUM_REGS = 28;
	localparam int REG_STATUS = 32;
	localparam int REG_ROUTE_COUNT = 33;
	localparam int REG_TERM_COUNT = 34;

	// Field positions
	localparam int CTRL_POST_ROUTE = 0;
	localparam int CTRL_NMI_ALIAS = 1;
	localparam int CTRL_LOW_GAME = 2;
	localparam int CTRL_HIGH_GAME = 3;
	localparam int PAR_EN = 0;
	localparam int PAR_SEL_LSB = 1;
	localparam int SER1_EN = 4;
	localparam int SER1_SEL_LSB = 5;
	localparam int SER2_EN = 8;
	localparam int SER2_SEL_LSB = 9;
	localparam int FDC_EN = 12;
	localparam int FDC_SEL = 13;
	localparam int EN_BIT = 31;
	localparam int IDE_SIZE32_BIT = 30;
	localparam int GEN_MASK_LSB = 16;
	localparam int PCIE_LIMIT_LSB = 16;
	localparam int STAT_PORT_LSB = 4;
	localparam int STAT_WRITE = 9;

	// Implemented bits, reset value of every register is zero
	localparam logic [31:0] MASK_CTRL = 32'h0000_000f;
	localparam logic [31:0] MASK_LEGACY = 32'h0000_3fff;
	localparam logic [31:0] MASK_EN_BASE = 32'h8000_ffff;
	localparam logic [31:0] MASK_IDE = 32'hc000_ffff;
	localparam logic [31:0] MASK_GEN = 32'h80ff_ffff;
	localparam logic [31:0] MASK_PCIE = 32'hffff_ffff;

	// Window sizes
	localparam logic [16:0] ACPI_LAST = 17'h0005f;
	localparam logic [15:0] SMB_MASK = 16'h001f;
	localparam logic [15:0] SATA_MASK = 16'h000f;
	localparam logic [15:0] KT_MASK = 16'h0007;
	localparam logic [15:0] IDE_MASK16 = 16'h000f;
	localparam logic [15:0] IDE_MASK32 = 16'h001f;
	localparam logic [15:0] LEGACY_MASK = 16'h0007;
	localparam logic [7:0] LPC_MIN_MASK = 8'h03;

	// Legacy peripheral locations
	localparam logic [1:0] PAR_SEL_NONE = 2'h3;
	localparam logic [2:0][15:0] PAR_LOC = {16'h03bc, 16'h0278, 16'h0378};
	localparam logic [7:0][15:0] SER_LOC = {16'h03e8, 16'h0338, 16'h02e8, 16'h0238,
		16'h0228, 16'h0220, 16'h02f8, 16'h03f8};
	localparam logic [1:0][15:0] FDC_LOC = {16'h0370, 16'h03f0};

	// Fixed addresses
	localparam logic [15:0] ADDR_POST = 16'h0080;
	localparam logic [15:0] ADDR_POST_A_LO = 16'h0084;
	localparam logic [15:0] ADDR_POST_A_HI = 16'h0086;
	localparam logic [15:0] ADDR_POST_B = 16'h0088;
	localparam logic [15:0] ADDR_POST_C_LO = 16'h008c;
	localparam logic [15:0] ADDR_POST_C_HI = 16'h008e;
	localparam logic [15:0] ALIAS_OFFSET = 16'h0010;
	localparam logic [11:0] ALIAS_BLOCK = 12'h009;
	localparam logic [15:0] ADDR_RESET_PORT = 16'h0092;
	localparam logic [15:0] ADDR_RESET_CTRL = 16'h0cf9;
	localparam logic [15:0] ADDR_NMI = 16'h0061;
	localparam logic [15:0] ADDR_NMI_A1 = 16'h0063;
	localparam logic [15:0] ADDR_NMI_A2 = 16'h0065;
	localparam logic [15:0] ADDR_NMI_A3 = 16'h0067;
	localparam logic [10:0] PIC_BLOCK = 11'h005;
	localparam logic [15:0] ADDR_PM = 16'h00b2;
	localparam logic [15:0] ADDR_PIC_ELCR = 16'h04d0;
	localparam logic [15:0] ADDR_GAME_LO = 16'h0200;
	localparam logic [15:0] ADDR_GAME_HI = 16'h0208;
	localparam logic [7:0] RESERVED_RDATA = 8'hff;

	// Variable windows, lower index wins
	localparam int WIN_ACPI = 0;
	localparam int WIN_IDE = 1;
	localparam int WIN_SMB = 2;
	localparam int WIN_WDT = 3;
	localparam int WIN_PAR = 4;
	localparam int WIN_SER1 = 5;
	localparam int WIN_SER2 = 6;
	localparam int WIN_FDC = 7;
	localparam int WIN_SATA = 8;
	localparam int WIN_KT = 9;
	localparam int WIN_LPC0 = 10;
	localparam int WIN_TRAP0 = 14;
	localparam int WIN_PCIE0 = 18;
	localparam int NUM_WIN = 30;

	typedef enum logic [3:0] {
		TGT_UNCLAIMED,
		TGT_RESERVED,
		TGT_INTERRUPT,
		TGT_RESET_GEN,
		TGT_POWER_MGMT,
		TGT_NMI,
		TGT_LPC,
		TGT_PCIE,
		TGT_SMBUS,
		TGT_TRAP,
		TGT_SATA,
		TGT_DISK_REDIRECT,
		TGT_KEYBOARD_TEXT
	} iod_target_e;

endpackage

//--- iod_window_match.sv
`timescale 1ns/1ps
module iod_window_match (
	// Cycle address
	input  wire logic        addr_en,
	input  wire logic [15:0] addr,
	// Window, limit inclusive
	input  wire logic [15:0] base,
	input  wire logic [16:0] limit,
	output logic             hit
);
	assign hit = addr_en && (addr >= base) && ({1'b0, addr} <= limit);
endmodule

//--- iod_fixed_decode.sv
`timescale 1ns/1ps
module iod_fixed_decode (
	// Cycle
	input  wire logic         [15:0] addr,
	input  wire logic                write,
	// Control bits
	input  wire logic                post_code_route_select,
	input  wire logic                nmi_port_alias_enable,
	input  wire logic                low_gameport_decode_enable,
	input  wire logic                high_gameport_decode_enable,
	// Decision
	output logic                     hit,
	output iod_pkg::iod_target_e     target,
	output logic              [15:0] fwd_addr
);
	import iod_pkg::*;

	function automatic logic is_post_port(input logic [15:0] a);
		return (a == ADDR_POST) || (a == ADDR_POST_B)
			|| (a >= ADDR_POST_A_LO && a <= ADDR_POST_A_HI)
			|| (a >= ADDR_POST_C_LO && a <= ADDR_POST_C_HI);
	endfunction

	iod_target_e post_tgt;
	logic [15:0] alias_addr;

	always_comb begin
		post_tgt = post_code_route_select ? TGT_PCIE : TGT_LPC;
		alias_addr = addr - ALIAS_OFFSET;
		hit = 1'b1;
		target = TGT_UNCLAIMED;
		fwd_addr = addr;
		if (addr == ADDR_POST) begin
			target = post_tgt;
		end else if (is_post_port(addr)) begin
			// Read side has no owner here
			target = write ? post_tgt : TGT_RESERVED;
		end else if (addr[15:4] == ALIAS_BLOCK && addr != ADDR_RESET_PORT
				&& is_post_port(alias_addr)) begin
			target = TGT_LPC;
			fwd_addr = alias_addr;
		end else if (addr == ADDR_RESET_PORT || addr == ADDR_RESET_CTRL) begin
			target = TGT_RESET_GEN;
		end else if (addr == ADDR_NMI) begin
			target = TGT_NMI;
		end else if (addr == ADDR_NMI_A1 || addr == ADDR_NMI_A2 || addr == ADDR_NMI_A3) begin
			if (nmi_port_alias_enable) begin
				target = TGT_NMI;
				fwd_addr = ADDR_NMI;
			end else begin
				target = TGT_PCIE;
			end
		end else if (addr[15:1] == ADDR_PM[15:1]) begin
			target = TGT_POWER_MGMT;
		end else if ((addr[15:5] == PIC_BLOCK && !addr[1])
				|| addr[15:1] == ADDR_PIC_ELCR[15:1]) begin
			target = TGT_INTERRUPT;
		end else if (addr[15:3] == ADDR_GAME_LO[15:3] && low_gameport_decode_enable) begin
			target = TGT_LPC;
		end else if (addr[15:3] == ADDR_GAME_HI[15:3] && high_gameport_decode_enable) begin
			target = TGT_LPC;
		end else begin
			hit = 1'b0;
		end
	end
endmodule

//--- iod_io_decoder_asserts.sv
`timescale 1ns/1ps
module iod_io_decoder_chk (
	// Clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	// Register bus
	input wire logic                 wb_cyc,
	input wire logic                 wb_stb,
	input wire logic                 wb_ack,
	// I/O cycle and decision
	input wire logic                 io_valid,
	input wire logic                 io_write,
	input wire logic          [15:0] io_addr,
	input wire logic                 rt_valid,
	input wire iod_pkg::iod_target_e rt_target,
	input wire logic          [15:0] rt_addr,
	input wire logic                 cpl_valid,
	input wire logic           [7:0] cpl_rdata
);
	import iod_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ack_pulse;
		wb_ack ##1 !wb_ack;
	endsequence
	sequence s_fwd(iod_target_e t);
		rt_valid && !cpl_valid && rt_target == t;
	endsequence
	chk_one_answer: assert property (io_valid |=> rt_valid != cpl_valid)
		else $error("io cycle answer count wrong");
	chk_quiet_idle: assert property (!io_valid |=> !rt_valid && !cpl_valid)
		else $error("answer without io cycle");
	chk_held_target: assert property (!io_valid |=> $stable(rt_target) && $stable(rt_addr))
		else $error("decision changed while idle");
	chk_wb_ack: assert property (wb_cyc && wb_stb && !wb_ack |=> s_ack_pulse)
		else $error("bus ack not a one cycle pulse");
	chk_reset_gen: assert property (io_valid && io_addr inside {16'h0092, 16'h0cf9}
		|=> s_fwd(TGT_RESET_GEN)) else $error("reset port misrouted");
	chk_pm_port: assert property (io_valid && io_addr[15:1] == 15'h0059
		|=> s_fwd(TGT_POWER_MGMT)) else $error("power port misrouted");
	chk_pic_pair: assert property (io_valid && (io_addr[15:5] == 11'h005 && !io_addr[1]
		|| io_addr[15:1] == 15'h0268) |=> s_fwd(TGT_INTERRUPT)) else $error("pic port misrouted");
	chk_post_read: assert property (io_valid && !io_write && io_addr inside {16'h0084,
		16'h0085, 16'h0086, 16'h0088, 16'h008c, 16'h008d, 16'h008e}
		|=> cpl_valid && rt_target == TGT_RESERVED && cpl_rdata == 8'hff)
		else $error("reserved read not completed with ones");
	chk_alias_port: assert property (io_valid && io_addr inside {16'h0090, 16'h0094,
		16'h0095, 16'h0096, 16'h0098, 16'h009c, 16'h009d, 16'h009e}
		|=> rt_valid && rt_target == TGT_LPC && rt_addr == $past(io_addr) - 16'h0010)
		else $error("alias port misrouted");
endmodule
bind iod_io_decoder iod_io_decoder_chk u_chk (.core_clk, .rst_n, .wb_cyc, .wb_stb, .wb_ack,
	.io_valid, .io_write, .io_addr, .rt_valid, .rt_target, .rt_addr, .cpl_valid, .cpl_rdata);

//--- iod_host_model.sv
`timescale 1ns/1ps
module iod_host_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Request from bench
	input  wire logic        req,
	input  wire logic        req_write,
	input  wire logic [15:0] req_addr,
	input  wire logic  [7:0] req_wdata,
	// I/O cycle to decoder
	output logic             io_valid,
	output logic             io_write,
	output logic      [15:0] io_addr,
	output logic       [7:0] io_wdata
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_valid <= 1'b0;
			io_write <= 1'b0;
			io_addr <= 16'h0000;
			io_wdata <= 8'h00;
		end else if (req) begin
			io_valid <= 1'b1;
			io_write <= req_write;
			io_addr <= req_addr;
			io_wdata <= req_wdata;
		end else begin
			// Idle lines wander so a stale address never looks like a request
			io_valid <= 1'b0;
			io_addr <= ~io_addr;
			io_wdata <= ~io_wdata;
		end
	end
endmodule

//--- iod_io_decoder_tb.sv
`timescale 1ns/1ps
module iod_io_decoder_tb;
	import iod_pkg::*;
	typedef struct {int t, a, w, d;} iod_exp_s;
	logic        core_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, req, req_write, due;
	logic        io_valid, io_write, rt_valid, rt_write, cpl_valid;
	logic  [7:0] wb_adr, io_wdata, rt_wdata, cpl_rdata, req_wdata;
	logic  [3:0] wb_sel;
	logic [31:0] wb_wdata, wb_rdata, rd;
	logic [15:0] io_addr, rt_addr, req_addr, a;
	logic  [4:0] rt_port;
	iod_target_e rt_target;
	iod_exp_s    q[$], last;
	int          num_errors, total_checks, n_fwd, n_term, m_ctrl, m_leg, m_smb, m_lpc;
	int          m_pcie, m_acpi, m_ide, m_trap;
	logic [11:0] fx_addr [45] = '{12'h000, 12'h061, 12'h063, 12'h065, 12'h067, 12'h080,
		12'h084, 12'h085, 12'h086, 12'h087, 12'h088, 12'h08c, 12'h08e, 12'h08f, 12'h090,
		12'h091, 12'h092, 12'h093, 12'h094, 12'h096, 12'h098, 12'h09c, 12'h09e, 12'h09f,
		12'h0a0, 12'h0a1, 12'h0a2, 12'h0a4, 12'h0ad, 12'h0b2, 12'h0b3, 12'h0b4, 12'h0bd,
		12'h0be, 12'h0c0, 12'h200, 12'h207, 12'h208, 12'h20f, 12'h210, 12'h4d0, 12'h4d1,
		12'h4d2, 12'hcf9, 12'hcf8};
	iod_io_decoder DUT (.core_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
		.wb_wdata, .wb_rdata, .wb_ack, .io_valid, .io_write, .io_addr, .io_wdata, .rt_valid,
		.rt_target, .rt_port, .rt_addr, .rt_write, .rt_wdata, .cpl_valid, .cpl_rdata);
	iod_host_model u_host (.core_clk, .rst_n, .req, .req_write, .req_addr, .req_wdata,
		.io_valid, .io_write, .io_addr, .io_wdata);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wb(input logic we, input int idx, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= 8'(idx * 4);
		wb_sel <= 4'hf;
		wb_wdata <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			num_errors++;
			close_out();
		end
		rd = wb_rdata;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic bit in8(input int a, input int loc);
		return a >= loc && a <= loc + 7;
	endfunction
	// Reference decode: fixed map first, then windows in priority order
	function automatic void model(input int a, input bit wr, output int t, output int ra);
		int m, mt;
		m = ((m_lpc >> 16) & 'hff) | 3;
		mt = (m_trap >> 16) & 'hff;
		ra = a;
		t = TGT_UNCLAIMED;
		if (a == 'h80 || wr && a inside {'h84, 'h85, 'h86, 'h88, 'h8c, 'h8d, 'h8e})
			t = m_ctrl[0] ? TGT_PCIE : TGT_LPC;
		else if (a inside {'h84, 'h85, 'h86, 'h88, 'h8c, 'h8d, 'h8e})
			t = TGT_RESERVED;
		else if (a inside {'h90, 'h94, 'h95, 'h96, 'h98, 'h9c, 'h9d, 'h9e}) begin
			t = TGT_LPC;
			ra = a - 'h10;
		end else if (a == 'h92 || a == 'hcf9)
			t = TGT_RESET_GEN;
		else if (a == 'hb2 || a == 'hb3)
			t = TGT_POWER_MGMT;
		else if (a >= 'ha0 && a < 'hc0 && !a[1] || a == 'h4d0 || a == 'h4d1)
			t = TGT_INTERRUPT;
		else if (a == 'h61)
			t = TGT_NMI;
		else if (a inside {'h63, 'h65, 'h67}) begin
			t = m_ctrl[1] ? TGT_NMI : TGT_PCIE;
			ra = m_ctrl[1] ? 'h61 : a;
		end else if ((a >> 3) == 'h40 && m_ctrl[2] || (a >> 3) == 'h41 && m_ctrl[3])
			t = TGT_LPC;
		else if (m_acpi[31] && a >= m_acpi[15:0] && a <= m_acpi[15:0] + 95)
			t = TGT_POWER_MGMT;
		else if (m_ide[31] && (a >> 4 + m_ide[30]) == (m_ide[15:0] >> 4 + m_ide[30]))
			t = TGT_DISK_REDIRECT;
		else if (m_smb[31] && (a >> 5) == (m_smb[15:0] >> 5))
			t = TGT_SMBUS;
		else if (m_leg[0] && m_leg[2:1] != 3 && in8(a, PAR_LOC[m_leg[2:1]])
				|| m_leg[4] && in8(a, SER_LOC[m_leg[7:5]])
				|| m_leg[8] && in8(a, SER_LOC[m_leg[11:9]])
				|| m_leg[12] && in8(a, FDC_LOC[m_leg[13]]))
			t = TGT_LPC;
		else if (m_lpc[31] && a >= (m_lpc & 'hffff & ~m) && a <= (m_lpc & 'hffff | m))
			t = TGT_LPC;
		else if (m_trap[31] && a >= (m_trap & 'hffff & ~mt) && a <= (m_trap & 'hffff | mt))
			t = TGT_TRAP;
		else if (m_pcie[15:0] <= m_pcie[31:16] && a >= m_pcie[15:0] && a <= m_pcie[31:16])
			t = TGT_PCIE;
	endfunction
	task automatic io(input logic [15:0] addr, input logic wr);
		iod_exp_s e;
		e.d = $urandom & 'hff;
		e.w = wr;
		model(addr, wr, e.t, e.a);
		q.push_back(e);
		req <= 1'b1;
		req_addr <= addr;
		req_write <= wr;
		req_wdata <= 8'(e.d);
		@(posedge core_clk);
	endtask
	// Outputs sampled before this edge updates them: answer to the cycle taken last edge
	always @(posedge core_clk) begin
		if (due && q.size() > 0) begin
			check("rt_valid", 32'(rt_valid), 32'(q[0].t > TGT_RESERVED));
			check("cpl_valid", 32'(cpl_valid), 32'(q[0].t <= TGT_RESERVED));
			check("rt_target", 32'(rt_target), q[0].t);
			if (q[0].t > TGT_RESERVED) begin
				n_fwd++;
				check("rt_addr", 32'(rt_addr), q[0].a);
				check("rt_data", 32'({rt_write, rt_port, rt_wdata}), q[0].w * 'h2000 + q[0].d);
			end else begin
				n_term++;
				check("cpl_rdata", 32'(cpl_rdata), q[0].w ? 0 : 'hff);
			end
			last = q[0];
			void'(q.pop_front());
		end
		due <= io_valid;
	end
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{wb_cyc, wb_stb, wb_we, req, req_write, due, rst_n} = '0;
		{wb_adr, wb_sel, wb_wdata, req_addr, req_wdata} = '0;
		{num_errors, total_checks, n_fwd, n_term, m_ctrl, m_leg, m_smb, m_lpc, m_pcie} = '0;
		void'($urandom(17330));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		foreach (fx_addr[i]) begin
			wb(0, i, 0);
			check("reset value", rd, 0);
		end
		$display("reset values done");
		// Idle root ports get base above limit, else a zero window claims address 0
		for (int p = 17; p < 28; p++)
			wb(1, p, 1);
		for (int k = 0; k < 4; k++) begin
			m_ctrl = k == 0 ? 0 : (k == 1 ? 'hf : $urandom & 'hf);
			m_leg = $urandom & 'h3fff;
			m_smb = $urandom & 'h8000_ffff;
			m_lpc = $urandom & 'h80ff_ffff;
			m_pcie = $urandom;
			m_acpi = $urandom & 'h8000_ffff;
			m_ide = $urandom & 'hc000_ffff;
			m_trap = $urandom & 'h80ff_ffff;
			wb(1, 0, m_ctrl | 'hfff0);
			wb(1, 1, m_leg);
			wb(1, 4, m_smb);
			wb(1, 8, m_lpc);
			wb(1, 16, m_pcie);
			wb(1, 2, m_acpi);
			wb(1, 3, m_ide);
			wb(1, 12, m_trap);
			wb(0, 0, 0);
			check("ctrl", rd, m_ctrl);
			wb(0, 1, 0);
			check("legacy", rd, m_leg);
			wb(1, 40, '1);
			wb(0, 40, 0);
			check("unmapped", rd, 0);
			foreach (fx_addr[i])
				for (int j = 0; j < 2; j++)
					io(16'(fx_addr[i]), j[0]);
			repeat (60) begin
				case ($urandom % 10)
					0: a = 16'(m_smb + $urandom % 40);
					1: a = 16'(m_lpc + $urandom % 300);
					2: a = 16'(m_pcie + $urandom % 64);
					3: a = 16'(PAR_LOC[$urandom % 3] + $urandom % 9);
					4: a = 16'(SER_LOC[$urandom % 8] + $urandom % 9);
					5: a = 16'(FDC_LOC[$urandom % 2] + $urandom % 9);
					6: a = 16'(m_acpi + $urandom % 100);
					7: a = 16'(m_ide + $urandom % 40);
					8: a = 16'(m_trap + $urandom % 300);
					default: a = 16'($urandom);
				endcase
				io(a, 1'($urandom));
			end
			req <= 1'b0;
			repeat (4) @(posedge core_clk);
			wb(0, 33, 0);
			check("route count", rd, n_fwd);
			wb(0, 34, 0);
			check("term count", rd, n_term);
			wb(0, 32, 0);
			check("status", rd, last.w * 'h200 + last.t);
			$display("config %0d done", k);
		end
		close_out();
	end
endmodule
